// ---- rtl/irq_enable_consts.svh ----
// Purpose: register offsets, field positions and reset values of the enable bank
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   offsets chosen for this bank
`ifndef IRQ_ENABLE_CONSTS_SVH
`define IRQ_ENABLE_CONSTS_SVH

// ---------------------------------------------------------------------------
// offsets
// ---------------------------------------------------------------------------
`define IEN_FIRST_OFS   12'h000
`define IEN_CTRL_OFS    12'h004
`define IEN_STATUS_OFS  12'h008

// ---------------------------------------------------------------------------
// field positions of the first enable register
// ---------------------------------------------------------------------------
`define IEN_TMR1_BIT    0
`define IEN_TMR2_BIT    1
`define IEN_CCP_BIT     2
`define IEN_GAP_LO_BIT  3
`define IEN_TX_BIT      4
`define IEN_RX_BIT      5
`define IEN_ADC_BIT     6
`define IEN_GAP_HI_BIT  7
`define IEN_WMASK       8'h77
`define IEN_RESET       8'h00

// ---------------------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------------------
`define CTRL_GATE_BIT   0
`define CTRL_PRIO_BIT   1
`define CTRL_RESET      2'h0

`endif

// ---- rtl/irq_enable_pkg.sv ----
// Purpose: shared types of the enable bank
// Assumes: nothing
// Notes:   constants live in the header
package irq_enable_pkg;
  typedef logic [7:0] enable_byte_t;
  typedef enum logic [2:0]
  {
    APB_IDLE   = 3'h1,
    APB_SETUP  = 3'h2,
    APB_ACCESS = 3'h4
  } apb_phase_t;
endpackage

// ---- rtl/irq_source_gate.sv ----
// Purpose: gate each peripheral request by its enable and by the global gate, which priority mode bypasses
// Assumes: requests and enables on mclk_i
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module irq_source_gate #(
  parameter int WIDTH = 8
)
(
  // requests and enables
  input  wire logic [WIDTH-1:0] req_i,
  input  wire logic [WIDTH-1:0] enable_i,
  // global gating
  input  wire logic             priority_mode_on_i,
  input  wire logic             global_peripheral_irq_gate_i,
  // result
  output logic      [WIDTH-1:0] pass_o
);
  logic gate_open;

  // ---------------------------------------------------------------------------
  // gating
  // ---------------------------------------------------------------------------
  assign gate_open = priority_mode_on_i | global_peripheral_irq_gate_i; // [R3]
  assign pass_o    = req_i & enable_i & {WIDTH{gate_open}};             // [R1]
endmodule // irq_source_gate
`default_nettype wire

// ---- rtl/peripheral_irq_enable_bank_one.sv ----
// Purpose: first peripheral interrupt enable register behind an apb slave
// Assumes: single clock mclk_i, synchronous active-high reset
// Notes:   requests are same-clock logic, passed without synchronisers
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_enable_consts.svh"

// Behaviour
// R1: per-source enable gates each request to core
// R2: this is the first of two enable registers
// R3: priority mode off needs global gate set
// R4: bits 7 and 3 read zero, ignore writes
// R5: bit 0 enables timer-one overflow interrupt
// R6: bits 6,5,4,2,1 enable other sources; reset zero
module peripheral_irq_enable_bank_one
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // peripheral requests, bit positions as the enable register
  input  wire logic        converter_done_req_i,
  input  wire logic        serial_receive_req_i,
  input  wire logic        serial_transmit_req_i,
  input  wire logic        capture_compare_req_i,
  input  wire logic        timer_two_match_req_i,
  input  wire logic        timer_one_overflow_req_i,
  // gated requests towards the core
  output logic      [7:0]  irq_pass_o,
  output logic             irq_any_o
);

  // ---------------------------------------------------------------------------
  // registers and internal nets
  // ---------------------------------------------------------------------------
  irq_enable_pkg::enable_byte_t enable_q;
  irq_enable_pkg::enable_byte_t enable_d;
  irq_enable_pkg::enable_byte_t en_vec;
  irq_enable_pkg::apb_phase_t   phase_q;
  irq_enable_pkg::apb_phase_t   phase_d;
  logic [1:0]                   ctrl_q;
  logic [1:0]                   ctrl_d;
  logic                         gate_on;
  logic                         prio_on;
  logic                         converter_done_irq_on;
  logic                         serial_receive_irq_on;
  logic                         serial_transmit_irq_on;
  logic                         capture_compare_irq_on;
  logic                         timer_two_match_irq_on;
  logic                         timer_one_overflow_irq_on;
  logic [7:0]                   req_vec;
  logic [7:0]                   pass_vec;
  logic                         xfer_on;
  logic                         access;
  logic                         answer;
  logic                         addr_ok;
  logic                         wr_commit;
  logic                         wr_first;
  logic                         wr_ctrl;
  logic [31:0]                  rd_d;
  logic [31:0]                  prdata_q;
  logic                         pslverr_q;
  logic [7:0]                   irq_pass_q;
  logic                         irq_any_q;

  // ---------------------------------------------------------------------------
  // address decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_first(input logic [11:0] a);
    is_first = (a == `IEN_FIRST_OFS);
  endfunction

  function automatic logic is_ctrl(input logic [11:0] a);
    is_ctrl = (a == `IEN_CTRL_OFS);
  endfunction

  function automatic logic is_status(input logic [11:0] a);
    is_status = (a == `IEN_STATUS_OFS);
  endfunction

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = is_first(a) || is_ctrl(a) || is_status(a);
  endfunction

  // drops the unimplemented enable bits
  function automatic irq_enable_pkg::enable_byte_t keep_implemented(
    input irq_enable_pkg::enable_byte_t v
  );
    keep_implemented                  = v & `IEN_WMASK;
    keep_implemented[`IEN_GAP_HI_BIT] = 1'b0;                      // [R4]
    keep_implemented[`IEN_GAP_LO_BIT] = 1'b0;                      // [R4]
  endfunction

  // ---------------------------------------------------------------------------
  // apb phase tracking: one wait state, answer in the second access cycle
  // ---------------------------------------------------------------------------
  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      irq_enable_pkg::APB_IDLE:
      begin
        if (psel_i && penable_i)
          phase_d = irq_enable_pkg::APB_ACCESS;
        else if (psel_i)
          phase_d = irq_enable_pkg::APB_SETUP;
        else
          phase_d = irq_enable_pkg::APB_IDLE;
      end
      // setup seen, waiting for the first access cycle
      irq_enable_pkg::APB_SETUP:
      begin
        if (psel_i && penable_i)
          phase_d = irq_enable_pkg::APB_ACCESS;
        else if (psel_i)
          phase_d = irq_enable_pkg::APB_SETUP;
        else
          phase_d = irq_enable_pkg::APB_IDLE;
      end
      // answer cycle: pready high, then back to idle
      irq_enable_pkg::APB_ACCESS:
      begin
        phase_d = irq_enable_pkg::APB_IDLE;
      end
      default:
      begin
        phase_d = irq_enable_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      phase_q <= irq_enable_pkg::APB_IDLE;
    else
      phase_q <= phase_d;
  end

  // ---------------------------------------------------------------------------
  // transfer decode: writes commit at the edge that completes the transfer
  // ---------------------------------------------------------------------------
  assign xfer_on   = psel_i & penable_i;
  assign access    = xfer_on & (phase_q != irq_enable_pkg::APB_ACCESS);
  assign answer    = (phase_q == irq_enable_pkg::APB_ACCESS);
  assign addr_ok   = known_addr(paddr_i);
  assign wr_commit = answer & xfer_on & pwrite_i & addr_ok & pstrb_i[0];
  assign wr_first  = wr_commit & is_first(paddr_i);                // [R2]
  assign wr_ctrl   = wr_commit & is_ctrl(paddr_i);

  // ---------------------------------------------------------------------------
  // first enable register (second register lives elsewhere)
  // ---------------------------------------------------------------------------
  always_comb
  begin
    enable_d = enable_q;
    if (wr_first)                                                  // [R2]
      enable_d = keep_implemented(pwdata_i[7:0]);                  // [R4] [R5] [R6]
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      enable_q <= `IEN_RESET;                                      // [R6]
    else
      enable_q <= enable_d;
  end

  // ---------------------------------------------------------------------------
  // named enable fields
  // ---------------------------------------------------------------------------
  assign converter_done_irq_on     = enable_q[`IEN_ADC_BIT];       // [R6]
  assign serial_receive_irq_on     = enable_q[`IEN_RX_BIT];        // [R6]
  assign serial_transmit_irq_on    = enable_q[`IEN_TX_BIT];        // [R6]
  assign capture_compare_irq_on    = enable_q[`IEN_CCP_BIT];       // [R6]
  assign timer_two_match_irq_on    = enable_q[`IEN_TMR2_BIT];      // [R6]
  assign timer_one_overflow_irq_on = enable_q[`IEN_TMR1_BIT];      // [R5]

  always_comb
  begin
    en_vec                     = 8'h00;
    en_vec[`IEN_ADC_BIT]       = converter_done_irq_on;
    en_vec[`IEN_RX_BIT]        = serial_receive_irq_on;
    en_vec[`IEN_TX_BIT]        = serial_transmit_irq_on;
    en_vec[`IEN_CCP_BIT]       = capture_compare_irq_on;
    en_vec[`IEN_TMR2_BIT]      = timer_two_match_irq_on;
    en_vec[`IEN_TMR1_BIT]      = timer_one_overflow_irq_on;        // [R5]
    en_vec[`IEN_GAP_LO_BIT]    = 1'b0;                             // [R4]
    en_vec[`IEN_GAP_HI_BIT]    = 1'b0;                             // [R4]
  end

  // ---------------------------------------------------------------------------
  // control register: global gate and priority mode
  // ---------------------------------------------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = pwdata_i[1:0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      ctrl_q <= `CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  assign gate_on = ctrl_q[`CTRL_GATE_BIT];
  assign prio_on = ctrl_q[`CTRL_PRIO_BIT];                         // [R3]

  // ---------------------------------------------------------------------------
  // request gating
  // ---------------------------------------------------------------------------
  always_comb
  begin
    req_vec                    = 8'h00;
    req_vec[`IEN_ADC_BIT]      = converter_done_req_i;
    req_vec[`IEN_RX_BIT]       = serial_receive_req_i;
    req_vec[`IEN_TX_BIT]       = serial_transmit_req_i;
    req_vec[`IEN_CCP_BIT]      = capture_compare_req_i;
    req_vec[`IEN_TMR2_BIT]     = timer_two_match_req_i;
    req_vec[`IEN_TMR1_BIT]     = timer_one_overflow_req_i;  // [R5]
  end

  irq_source_gate #(
    .WIDTH (8)
  ) u_gate (
    .req_i                        (req_vec),
    .enable_i                     (en_vec),                         // [R1]
    .priority_mode_on_i           (prio_on),                        // [R3]
    .global_peripheral_irq_gate_i (gate_on),
    .pass_o                       (pass_vec)
  );

  // ---------------------------------------------------------------------------
  // gated requests towards the core, one cycle after a change
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      irq_pass_q <= 8'h00;
    else
      irq_pass_q <= pass_vec;                                      // [R1]
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      irq_any_q <= 1'b0;
    else
      irq_any_q <= |pass_vec;
  end

  assign irq_pass_o = irq_pass_q;
  assign irq_any_o  = irq_any_q;

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // unmapped offsets and gap bits read zero
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (is_first(paddr_i))
      rd_d[7:0] = keep_implemented(enable_q);                      // [R4]
    else if (is_ctrl(paddr_i))
      rd_d[1:0] = ctrl_q;
    else if (is_status(paddr_i))
      rd_d[7:0] = pass_vec;
    else
      rd_d = 32'h0000_0000;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      prdata_q <= 32'h0000_0000;
    else if (access)
      prdata_q <= pwrite_i ? 32'h0000_0000 : rd_d;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      pslverr_q <= 1'b0;
    else if (access)
      pslverr_q <= ~addr_ok;
  end

  // ---------------------------------------------------------------------------
  // apb outputs
  // ---------------------------------------------------------------------------
  assign pready_o  = answer;
  assign prdata_o  = prdata_q;
  assign pslverr_o = pslverr_q & answer;
endmodule // peripheral_irq_enable_bank_one
`default_nettype wire

// ---- tb/irq_bank_props.sv ----
// Purpose: port assertions of the enable bank
// Assumes: apb writes land at the pready edge
// Notes:   shadows mirror enable and gate state
`timescale 1ns/1ps
`default_nettype none
module irq_bank_props
(
  // watched ports
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        serial_receive_req_i,
  input wire logic        timer_one_overflow_req_i,
  input wire logic [7:0]  irq_pass_o
);
  logic [7:0] en_q;
  logic       open_q;
  wire logic  wr = psel_i && pready_o && pwrite_i && pstrb_i[0];
  always_ff @(posedge mclk_i)
    if (reset_i)
    begin
      en_q   <= 8'h00;
      open_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr_i == 12'h000)
        en_q <= pwdata_i[7:0] & 8'h77;
      if (wr && paddr_i == 12'h004)
        open_q <= |pwdata_i[1:0];
    end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  req_gate_a: assert property (irq_pass_o[5] |-> $past(serial_receive_req_i))
    else $error("pass without request");
  first_reg_a: assert property (pready_o && paddr_i == 12'h000 |-> !pslverr_o)
    else $error("enable register refused");
  global_gate_a: assert property (|irq_pass_o |-> $past(open_q))
    else $error("pass while gate closed");
  gap_pass_a: assert property (!irq_pass_o[7] && !irq_pass_o[3])
    else $error("pass on gap bit");
  read_back_a: assert property (pready_o && !pwrite_i && paddr_i == 12'h000 |->
    prdata_o[7:0] == en_q)
    else $error("enable readback wrong");
  tmr_one_a: assert property ($past(en_q[0] && open_q && timer_one_overflow_req_i)
    |-> irq_pass_o[0])
    else $error("timer one pass missing");
  enable_mask_a: assert property ((irq_pass_o & ~$past(en_q)) == 8'h00)
    else $error("pass of disabled source");
endmodule // irq_bank_props
bind peripheral_irq_enable_bank_one irq_bank_props i_irq_bank_props (.*);
`default_nettype wire

// ---- tb/irq_source_model.sv ----
// Purpose: peripheral request sources
// Assumes: level requests on mclk_i
// Notes:   gap positions never request
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
(
  input  wire logic       mclk_i,
  input  wire logic [7:0] raise_i,
  output logic      [7:0] req_o
);
  always_ff @(posedge mclk_i)
    req_o <= raise_i & 8'h77;
endmodule // irq_source_model
`default_nettype wire

// ---- tb/tb_peripheral_irq_enable_bank_one.sv ----
// Purpose: self-checking bench of the enable bank
// Assumes: apb answer in two access cycles
// Notes:   no random stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_irq_enable_bank_one;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, any_irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0] raise = 8'h00, req, pass;
  logic e;
  int fails = 0, samples_checked = 0;
  irq_source_model i_irq_source_model (.mclk_i(mclk), .raise_i(raise), .req_o(req));
  peripheral_irq_enable_bank_one i_peripheral_irq_enable_bank_one (.mclk_i(mclk),
    .reset_i(reset), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .converter_done_req_i(req[6]), .serial_receive_req_i(req[5]),
    .serial_transmit_req_i(req[4]), .capture_compare_req_i(req[2]),
    .timer_two_match_req_i(req[1]), .timer_one_overflow_req_i(req[0]),
    .irq_pass_o(pass), .irq_any_o(any_irq));
  initial
    forever #10 mclk = ~mclk;
  task automatic finish_test;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      fails++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs;
    apb(0, 12'h000, 0);
    chk(r, 0);
    apb(1, 12'h000, 32'hffffffff);
    apb(0, 12'h000, 0);
    chk(r, 32'h77);
    apb(0, 12'h0fc, 0);
    chk(r, 0);
    chk(e, 1);
  endtask
  task automatic t_each;
    int b [6] = '{0, 1, 2, 4, 5, 6};
    raise <= 8'hff;
    apb(1, 12'h004, 1);
    foreach (b[k])
    begin
      apb(1, 12'h000, 32'h1 << b[k]);
      repeat (3) @(posedge mclk);
      chk(pass, 8'h1 << b[k]);
    end
  endtask
  task automatic t_gate;
    apb(1, 12'h000, 32'h77);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, 12'h004, c);
      repeat (3) @(posedge mclk);
      chk({any_irq, pass}, (c == 0) ? 9'h000 : 9'h177);
      apb(0, 12'h008, 0);
      chk(r, (c == 0) ? 32'h0 : 32'h77);
    end
  endtask
  task automatic t_reset;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({any_irq, pass}, 9'h000);
    apb(0, 12'h000, 0);
    chk(r, 0);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_each();
    t_gate();
    t_reset();
    finish_test();
  end
endmodule // tb_peripheral_irq_enable_bank_one
`default_nettype wire
